/* File: core/cev_pkg.sv */
package cev_pkg;
   // exception vector numbers
   localparam logic [7:0] VEC_ADDR_ERR  = 8'h03;
   localparam logic [7:0] VEC_ILLEGAL   = 8'h04;
   localparam logic [7:0] VEC_PRIV      = 8'h08;
   localparam logic [7:0] VEC_ALINE     = 8'h0a;
   localparam logic [7:0] VEC_FLINE     = 8'h0b;
   localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
   // status word bit positions
   localparam int SR_S_BIT  = 13;
   localparam int SR_T0_BIT = 14;
   localparam int SR_T1_BIT = 15;
   // opcode line codes and cpu space type
   localparam logic [3:0] OP_ALINE     = 4'ha;
   localparam logic [3:0] OP_FLINE     = 4'hf;
   localparam logic [3:0] CPU_SPACE_CP = 4'h2;
   // register offsets and reset values
   localparam logic [7:0]  REG_VBR  = 8'h00;
   localparam logic [7:0]  REG_STAT = 8'h04;
   localparam logic [7:0]  REG_PC   = 8'h08;
   localparam logic [31:0] VBR_RST  = 32'h0000_0000;
   // stack frame kinds
   typedef enum logic [1:0] {
      FR_PC_ONLY = 2'h0,
      FR_PC_PTR  = 2'h1,
      FR_SHORT   = 2'h2,
      FR_LONG    = 2'h3
   } cev_frame_e;
   // instruction trap kinds
   typedef enum logic [2:0] {
      TK_NONE   = 3'h0,
      TK_NUMBER = 3'h1,
      TK_COND   = 3'h2,
      TK_DIVIDE = 3'h3
   } cev_trap_e;
   // controller states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_CPCYC = 3'h2,
      ST_HALT  = 3'h4
   } cev_state_e;
   // decoded instruction from the core
   typedef struct packed {
      logic        valid;
      logic [15:0] opcode;
      logic        illegal;
      logic        control_register_move_bad;
      logic        ext_undef;
      logic        privileged;
      cev_trap_e   trap;
      logic [3:0]  trap_num;
      logic [7:0]  trap_vec;
      logic        cond_true;
      logic        div_zero;
      logic [31:0] pc;
      logic [31:0] next_pc;
      logic [15:0] sr;
   } cev_instr_s;
   // exception record to the stacking logic
   typedef struct packed {
      logic        valid;
      logic [7:0]  vec;
      logic [15:0] offset;
      logic [31:0] handler;
      logic [15:0] sr_copy;
      logic [15:0] sr_new;
      logic [31:0] pc;
      logic [31:0] ptr;
      logic        has_ptr;
      cev_frame_e  frame;
   } cev_exc_s;
   // coprocessor access cycle request
   typedef struct packed {
      logic       req;
      logic [3:0] space;
      logic [2:0] cp_id;
   } cev_cp_s;
endpackage

/* File: core/cev_core.sv */
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
// Behaviour
// - odd prefetch: no bus cycle, address error
// - address error uses vector 3, fault frame
// - address error during fault processing: double fault
// - numbered trap vector is 32 plus n
// - conditional traps fire only when condition true
// - divide by zero raises trap
// - trap: copy status, supervisor, clear trace
// - traced trap: trace only after handler return
// - trap frame stacks next instruction address
// - non-numbered traps also stack instruction pointer
// - bad opcode or control move: vector 4
// - breakpoint cycle bus error: illegal instruction
// - A-line opcode raises vector 10
// - undefined MMU op: F-line or privilege
// - coprocessor op runs cpu space cycle
// - coprocessor cycle bus error: F-line exception
// - unimplemented ops stack their own address
// - privileged ops in user mode violate
// - coprocessor privilege check in user violates
// - privilege violation vector 8, own address
// - double fault halts, status held continuously
module cev_core (
   // clock, reset, enable
   input  wire logic               clk_in,
   input  wire logic               rst_n_in,
   input  wire logic               ce_in,
   // prefetch port
   input  wire logic               fetch_req_in,
   input  wire logic [31:0]        fetch_addr_in,
   input  wire logic               fetch_mid_in,
   output logic                    fetch_go_out,
   // decoded instruction port
   input  wire cev_pkg::cev_instr_s instr_in,
   output logic                    instr_ready_out,
   // core sequencing
   input  wire logic               fault_seq_in,
   input  wire logic               exc_done_in,
   input  wire logic               rte_done_in,
   // coprocessor and breakpoint pins
   output cev_pkg::cev_cp_s        cp_cycle_out,
   input  wire logic               cp_ack_pin_in,
   input  wire logic               cp_berr_pin_in,
   input  wire logic               cp_priv_pin_in,
   input  wire logic               breakpoint_instruction_berr_pin_in,
   output logic                    cop_ok_out,
   // exception results
   output cev_pkg::cev_exc_s       exc_out,
   output logic                    halt_status_out,
   output logic                    trace_req_out,
   // register port
   input  wire logic [7:0]         reg_addr_in,
   input  wire logic [31:0]        reg_wdata_in,
   input  wire logic               reg_wr_in,
   input  wire logic               reg_rd_in,
   output logic [31:0]             reg_rdata_out
);

   // pin synchronisers: ack, berr, priv, breakpoint_instruction berr
   logic [3:0]          sync1_q;
   logic [3:0]          sync2_q;
   logic                breakpoint_instruction_seen_q;
   // control state
   cev_pkg::cev_state_e st_q;
   logic                busy_q;
   logic                fault_act_q;
   logic                trace_pend_q;
   logic                breakpoint_instruction_pend_q;
   // coprocessor context
   cev_pkg::cev_cp_s    cp_q;
   logic [31:0]         cp_pc_q;
   logic [15:0]         cp_sr_q;
   // registers
   logic [31:0]         vbr_q;
   logic [31:0]         last_pc_q;
   logic [7:0]          last_vec_q;
   cev_pkg::cev_exc_s   exc_q;
   logic                cop_ok_q;
   logic                trace_req_q;
   logic [31:0]         rdata_q;
   // decode results
   logic                odd_fetch;
   logic                dbl_fault;
   logic                accept;
   logic                cp_start;
   logic                cp_ok;
   logic                breakpoint_instruction_edge;
   logic                ev_hit;
   logic                ev_addr;
   logic                ev_trap;
   logic [7:0]          ev_vec;
   logic [31:0]         ev_pc;
   logic [31:0]         ev_ptr;
   logic                ev_has_ptr;
   cev_pkg::cev_frame_e ev_frame;
   logic [15:0]         ev_sr;
   logic                user_mode;
   logic                trap_fire;

   // status word after entry to supervisor
   function automatic logic [15:0] sup_sr(input logic [15:0] sr);
      logic [15:0] r;
      r = sr;
      r[cev_pkg::SR_S_BIT] = 1'b1;
      r[cev_pkg::SR_T0_BIT] = 1'b0;
      r[cev_pkg::SR_T1_BIT] = 1'b0;
      return r;
   endfunction

   // two flip-flop pin synchroniser
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sync1_q <= 4'h0;
         sync2_q <= 4'h0;
         breakpoint_instruction_seen_q <= 1'b0;
      end else if (ce_in) begin
         sync1_q <= {breakpoint_instruction_berr_pin_in, cp_priv_pin_in, cp_berr_pin_in, cp_ack_pin_in};
         sync2_q <= sync1_q;
         breakpoint_instruction_seen_q <= sync2_q[3];
      end
   end

   // breakpoint bus error edge from stable stage
   assign breakpoint_instruction_edge = sync2_q[3] & ~breakpoint_instruction_seen_q;

   // odd prefetch and double fault detection
   assign odd_fetch = fetch_req_in & fetch_addr_in[0];
   assign dbl_fault = odd_fetch & (fault_seq_in | fault_act_q);
   // no bus cycle on odd address or while halted
   assign fetch_go_out = fetch_req_in & ~fetch_addr_in[0] & (st_q != cev_pkg::ST_HALT);

   // instruction taken when idle and not stacking
   assign instr_ready_out = (st_q == cev_pkg::ST_IDLE) & ~busy_q & ~odd_fetch & ~breakpoint_instruction_pend_q;
   assign accept = ce_in & instr_ready_out & instr_in.valid;
   assign user_mode = ~instr_in.sr[cev_pkg::SR_S_BIT];
   // trap condition per kind
   always_comb begin
      case (instr_in.trap)
         cev_pkg::TK_NUMBER: trap_fire = 1'b1;
         cev_pkg::TK_COND:   trap_fire = instr_in.cond_true;
         cev_pkg::TK_DIVIDE: trap_fire = instr_in.div_zero;
         default:            trap_fire = 1'b0;
      endcase
   end

   // event merge by priority
   always_comb begin
      ev_hit = 1'b0;
      ev_addr = 1'b0;
      ev_trap = 1'b0;
      ev_vec = cev_pkg::VEC_ILLEGAL;
      ev_pc = instr_in.pc;
      ev_ptr = instr_in.pc;
      ev_has_ptr = 1'b0;
      ev_frame = cev_pkg::FR_PC_ONLY;
      ev_sr = instr_in.sr;
      cp_start = 1'b0;
      cp_ok = 1'b0;
      if (!ce_in || st_q == cev_pkg::ST_HALT) begin
         // frozen or halted: nothing
         ev_hit = 1'b0;
      end else if (st_q == cev_pkg::ST_CPCYC) begin
         // coprocessor answer
         ev_pc = cp_pc_q;
         ev_sr = cp_sr_q;
         if (sync2_q[1]) begin
            ev_hit = 1'b1;
            ev_vec = cev_pkg::VEC_FLINE;
         end else if (sync2_q[0] && sync2_q[2] && !cp_sr_q[cev_pkg::SR_S_BIT]) begin
            ev_hit = 1'b1;
            ev_vec = cev_pkg::VEC_PRIV;
         end else if (sync2_q[0]) begin
            cp_ok = 1'b1;
         end
      end else if (odd_fetch && !busy_q && !dbl_fault) begin
         // address error, frame by fault position
         ev_hit = 1'b1;
         ev_addr = 1'b1;
         ev_vec = cev_pkg::VEC_ADDR_ERR;
         ev_frame = fetch_mid_in ? cev_pkg::FR_LONG : cev_pkg::FR_SHORT;
      end else if (breakpoint_instruction_pend_q && !busy_q) begin
         ev_hit = 1'b1;
         ev_vec = cev_pkg::VEC_ILLEGAL;
      end else if (accept) begin
         if (instr_in.illegal || instr_in.control_register_move_bad) begin
            ev_hit = 1'b1;
            ev_vec = cev_pkg::VEC_ILLEGAL;
         end else if (instr_in.opcode[15:12] == cev_pkg::OP_ALINE) begin
            ev_hit = 1'b1;
            ev_vec = cev_pkg::VEC_ALINE;
         end else if (instr_in.opcode[15:12] == cev_pkg::OP_FLINE && instr_in.opcode[11:9] == 3'h0) begin
            // memory management group
            if (user_mode) begin
               ev_hit = 1'b1;
               ev_vec = cev_pkg::VEC_PRIV;
            end else if (instr_in.ext_undef) begin
               ev_hit = 1'b1;
               ev_vec = cev_pkg::VEC_FLINE;
            end
         end else if (instr_in.opcode[15:12] == cev_pkg::OP_FLINE) begin
            cp_start = 1'b1;
         end else if (instr_in.privileged && user_mode) begin
            ev_hit = 1'b1;
            ev_vec = cev_pkg::VEC_PRIV;
         end else if (trap_fire) begin
            // instruction trap, stacks next address
            ev_hit = 1'b1;
            ev_trap = 1'b1;
            ev_pc = instr_in.next_pc;
            if (instr_in.trap == cev_pkg::TK_NUMBER) begin
               ev_vec = cev_pkg::VEC_TRAP_BASE + {4'h0, instr_in.trap_num};
            end else begin
               ev_vec = instr_in.trap_vec;
               ev_has_ptr = 1'b1;
               ev_frame = cev_pkg::FR_PC_PTR;
            end
         end
      end
   end

   // controller state
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         st_q <= cev_pkg::ST_IDLE;
      end else if (ce_in) begin
         case (st_q)
            cev_pkg::ST_IDLE: begin
               if (dbl_fault) begin
                  st_q <= cev_pkg::ST_HALT;
               end else if (cp_start) begin
                  st_q <= cev_pkg::ST_CPCYC;
               end
            end
            cev_pkg::ST_CPCYC: begin
               if (dbl_fault) begin
                  st_q <= cev_pkg::ST_HALT;
               end else if (ev_hit || cp_ok) begin
                  st_q <= cev_pkg::ST_IDLE;
               end
            end
            cev_pkg::ST_HALT: begin
               st_q <= cev_pkg::ST_HALT;
            end
            default: begin
               st_q <= cev_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // busy, fault and pending flags; set wins clear
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         busy_q <= 1'b0;
         fault_act_q <= 1'b0;
         breakpoint_instruction_pend_q <= 1'b0;
      end else if (ce_in) begin
         busy_q <= ev_hit | (busy_q & ~exc_done_in);
         fault_act_q <= ev_addr | (fault_act_q & ~exc_done_in);
         breakpoint_instruction_pend_q <= breakpoint_instruction_edge | (breakpoint_instruction_pend_q & ~(ev_hit & (ev_vec == cev_pkg::VEC_ILLEGAL) & ~accept));
      end
   end

   // deferred trace of a traced trap
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         trace_pend_q <= 1'b0;
         trace_req_q <= 1'b0;
      end else if (ce_in) begin
         trace_req_q <= trace_pend_q & rte_done_in;
         if (ev_trap && (instr_in.sr[cev_pkg::SR_T1_BIT] || instr_in.sr[cev_pkg::SR_T0_BIT])) begin
            trace_pend_q <= 1'b1;
         end else if (rte_done_in) begin
            trace_pend_q <= 1'b0;
         end
      end
   end

   // coprocessor cycle request and context
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cp_q <= '0;
         cp_pc_q <= 32'h0000_0000;
         cp_sr_q <= 16'h0000;
         cop_ok_q <= 1'b0;
      end else if (ce_in) begin
         cop_ok_q <= cp_ok;
         if (cp_start) begin
            cp_q.req <= 1'b1;
            cp_q.space <= cev_pkg::CPU_SPACE_CP;
            cp_q.cp_id <= instr_in.opcode[11:9];
            cp_pc_q <= instr_in.pc;
            cp_sr_q <= instr_in.sr;
         end else if (st_q == cev_pkg::ST_CPCYC && (ev_hit || cp_ok || dbl_fault)) begin
            cp_q.req <= 1'b0;
         end
      end
   end

   // exception record, one cycle valid
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         exc_q <= '0;
      end else if (ce_in) begin
         exc_q.valid <= ev_hit;
         if (ev_hit) begin
            exc_q.vec <= ev_vec;
            exc_q.offset <= {6'h00, ev_vec, 2'b00};
            exc_q.handler <= vbr_q + {22'h000000, ev_vec, 2'b00};
            exc_q.sr_copy <= ev_sr;
            exc_q.sr_new <= sup_sr(ev_sr);
            exc_q.pc <= ev_pc;
            exc_q.ptr <= ev_ptr;
            exc_q.has_ptr <= ev_has_ptr;
            exc_q.frame <= ev_frame;
         end
      end
   end

   // vector base register and last event capture
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         vbr_q <= cev_pkg::VBR_RST;
         last_pc_q <= 32'h0000_0000;
         last_vec_q <= 8'h00;
      end else if (ce_in) begin
         if (reg_wr_in && reg_addr_in == cev_pkg::REG_VBR) begin
            vbr_q <= reg_wdata_in;
         end
         if (ev_hit) begin
            last_pc_q <= ev_pc;
            last_vec_q <= ev_vec;
         end
      end
   end

   // read data, one cycle after strobe
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rdata_q <= 32'h0000_0000;
      end else if (ce_in) begin
         rdata_q <= 32'h0000_0000;
         if (reg_rd_in) begin
            case (reg_addr_in)
               cev_pkg::REG_VBR:  rdata_q <= vbr_q;
               cev_pkg::REG_STAT: rdata_q <= {20'h00000, halt_status_out, trace_pend_q,
                                              fault_act_q, busy_q, last_vec_q};
               cev_pkg::REG_PC:   rdata_q <= last_pc_q;
               default:           rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // outputs
   assign halt_status_out = (st_q == cev_pkg::ST_HALT);
   assign exc_out = exc_q;
   assign cp_cycle_out = cp_q;
   assign cop_ok_out = cop_ok_q;
   assign trace_req_out = trace_req_q;
   assign reg_rdata_out = rdata_q;

   // checks
   odd_no_bus_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      odd_fetch |-> !fetch_go_out) else $error("odd prefetch ran a bus cycle");
   addr_err_vec_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && odd_fetch && st_q == cev_pkg::ST_IDLE && !busy_q && !dbl_fault
      |=> exc_q.valid && exc_q.vec == 8'h03 && exc_q.frame inside {cev_pkg::FR_SHORT, cev_pkg::FR_LONG})
      else $error("address error not vector 3");
   double_fault_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && dbl_fault && st_q != cev_pkg::ST_CPCYC |=> halt_status_out)
      else $error("double fault did not halt");
   halt_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      halt_status_out |=> halt_status_out && !exc_q.valid && !fetch_go_out)
      else $error("halt released without reset");
   trap_number_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ev_trap && instr_in.trap == cev_pkg::TK_NUMBER
      |=> exc_q.vec == 8'h20 + {4'h0, $past(instr_in.trap_num)} && !exc_q.has_ptr
          && exc_q.pc == $past(instr_in.next_pc)) else $error("numbered trap record wrong");
   trap_ptr_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ev_trap && instr_in.trap != cev_pkg::TK_NUMBER
      |=> exc_q.has_ptr && exc_q.ptr == $past(instr_in.pc)) else $error("trap pointer missing");
   sr_entry_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      exc_q.valid |-> exc_q.sr_new[15:13] == 3'b001 && exc_q.sr_new[12:0] == exc_q.sr_copy[12:0])
      else $error("status entry wrong");
   offset_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      exc_q.valid |-> exc_q.offset == {6'h00, exc_q.vec, 2'b00}
      && exc_q.handler == $past(vbr_q) + {16'h0000, exc_q.offset}) else $error("vector offset wrong");
   priv_viol_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      accept && ev_hit && ev_vec == 8'h08 |=> exc_q.vec == 8'h08 && exc_q.pc == $past(instr_in.pc))
      else $error("privilege violation record wrong");
   cp_cycle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      st_q == cev_pkg::ST_CPCYC |-> cp_q.req && cp_q.space == 4'h2) else $error("no cpu space cycle");
   cp_berr_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && st_q == cev_pkg::ST_CPCYC && sync2_q[1] |=> exc_q.valid && exc_q.vec == 8'h0b
      && exc_q.pc == cp_pc_q) else $error("coprocessor bus error not F-line");
   trace_defer_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && trace_pend_q && rte_done_in |=> trace_req_out ##1 !trace_req_out || !ce_in)
      else $error("deferred trace lost");
endmodule

/* File: bench/cev_partner.sv */
`timescale 1ns/1ps
// far side: coprocessor and breakpoint logic
module cev_partner (
   // clock and command from the bench
   input  wire logic             clk_in,
   input  wire logic [1:0]       mode_in,
   input  wire logic             breakpoint_instruction_in,
   input  wire cev_pkg::cev_cp_s cp_in,
   // answer pins
   output logic                  ack_out,
   output logic                  berr_out,
   output logic                  priv_out,
   output logic                  breakpoint_instruction_berr_out
);
   logic [1:0] wait_q = 2'h0; // slow answer delay
   logic       hit;           // delay ran out
   assign hit = cp_in.req && wait_q == 2'h3;
   // answer late, hold until req drops, then release
   always_ff @(posedge clk_in) begin
      wait_q <= cp_in.req ? wait_q + {1'h0, !hit} : 2'h0;
      ack_out <= hit && mode_in != 2'h1;
      berr_out <= hit && mode_in == 2'h1;
      priv_out <= hit && mode_in == 2'h2;
      breakpoint_instruction_berr_out <= breakpoint_instruction_in;
   end
endmodule

/* File: bench/cev_core_tb.sv */
`timescale 1ns/1ps
// self-checking bench for the exception unit
module cev_core_tb;
   // row: instruction fields, partner mode, expected result
   typedef struct packed {
      logic [15:0] op;
      logic [5:0]  fl;
      logic [2:0]  tk;
      logic [3:0]  n;
      logic [7:0]  tv;
      logic [15:0] sr;
      logic [1:0]  md;
      logic [7:0]  vec;
      logic        nx;
      logic        pt;
   } cev_row_s;
   localparam logic [31:0] PC  = 32'h1000;      // instruction address
   localparam logic [31:0] NPC = 32'h1004;      // next instruction
   localparam cev_row_s    TR  = '{16'h4e41, 6'h0, 3'h1, 4'h1, 8'h0, 16'h8000, 2'h0, 8'h21, 1'h1, 1'h0};
   // fault rows take status and pc from the last instruction held on the port
   localparam cev_row_s    AE  = '{16'h0, 6'h0, 3'h0, 4'h0, 8'h0, 16'h8000, 2'h0, 8'h03, 1'h0, 1'h0};
   localparam cev_row_s    BK  = '{16'h0, 6'h0, 3'h0, 4'h0, 8'h0, 16'h8000, 2'h0, 8'h04, 1'h0, 1'h0};
   logic clk = 1'h0, rst_n = 1'h0, f_req = 1'h0, f_mid = 1'h0, f_seq = 1'h0;
   logic x_done = 1'h0, return_from_exception = 1'h0, breakpoint_instruction = 1'h0, wr = 1'h0, rd = 1'h0;
   logic [31:0] f_addr = 32'h0, wdata = 32'h0, rdata, d;
   logic [7:0] addr = 8'h0;
   logic [1:0] mode = 2'h0;
   cev_pkg::cev_instr_s instr = '0;
   cev_pkg::cev_cp_s cp;
   cev_pkg::cev_exc_s exc;
   logic go, ready, ack, berr, priv, bkb, cop_ok, halt, trace, got;
   int num_errors = 0, cmp_count = 0;
   cev_row_s rows [14];
   // device under test
   cev_core DUT (.clk_in(clk), .rst_n_in(rst_n), .ce_in(1'h1), .fetch_req_in(f_req),
      .fetch_addr_in(f_addr), .fetch_mid_in(f_mid), .fetch_go_out(go), .instr_in(instr),
      .instr_ready_out(ready), .fault_seq_in(f_seq), .exc_done_in(x_done), .rte_done_in(return_from_exception),
      .cp_cycle_out(cp), .cp_ack_pin_in(ack), .cp_berr_pin_in(berr), .cp_priv_pin_in(priv),
      .breakpoint_instruction_berr_pin_in(bkb), .cop_ok_out(cop_ok), .exc_out(exc), .halt_status_out(halt),
      .trace_req_out(trace), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata));
   // far side model
   cev_partner PTN (.clk_in(clk), .mode_in(mode), .breakpoint_instruction_in(breakpoint_instruction), .cp_in(cp), .ack_out(ack),
      .berr_out(berr), .priv_out(priv), .breakpoint_instruction_berr_out(bkb));
   // 50 MHz clock
   always #10 clk = ~clk;
   // compare and count
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // register read, data one cycle later
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      rd <= 1'h1;
      addr <= a;
      @(posedge clk);
      rd <= 1'h0;
      @(negedge clk);
      d = rdata;
   endtask
   // hold one instruction until accepted
   task automatic send(input cev_row_s r);
      mode <= r.md;
      instr <= '{1'h1, r.op, r.fl[5], r.fl[4], r.fl[3], r.fl[2], cev_pkg::cev_trap_e'(r.tk), r.n, r.tv,
                 r.fl[1], r.fl[0], PC, NPC, r.sr};
      @(negedge clk);
      for (int k = 0; k < 20 && ready !== 1'h1; k++) @(negedge clk);
      @(posedge clk);
      instr.valid <= 1'h0;
   endtask
   // wait for a record or an acknowledge
   task automatic wait_exc();
      for (int k = 0; k < 20 && exc.valid !== 1'h1 && cop_ok !== 1'h1; k++) @(negedge clk);
      got = exc.valid;
   endtask
   // check the record, then free the unit
   task automatic check(input cev_row_s r);
      chk("taken", 32'(r.vec != 8'h0), 32'(got));
      if (got === 1'h1) begin
         chk("vector", 32'(r.vec), 32'(exc.vec));
         chk("offset", 32'({r.vec, 2'h0}), 32'(exc.offset));
         chk("handler", 32'h100 + 32'({r.vec, 2'h0}), exc.handler);
         chk("status copy", 32'(r.sr), 32'(exc.sr_copy));
         chk("new status", 32'((r.sr | 16'h2000) & 16'h3fff), 32'(exc.sr_new));
         chk("pc", r.nx ? NPC : PC, exc.pc);
         chk("pointer", 32'(r.pt), 32'(exc.has_ptr));
         if (r.pt) chk("pointer value", PC, exc.ptr);
         @(posedge clk);
         x_done <= 1'h1;
         @(posedge clk);
         x_done <= 1'h0;
      end
      $display("test vector %h done", r.vec);
   endtask
   // verdict
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      finish_test();
   end
   // main sequence
   initial begin
      rows = '{'{16'h4e45, 6'h00, 3'h1, 4'h5, 8'h0, 16'h0, 2'h0, 8'h25, 1'h1, 1'h0},
               '{16'h4e4f, 6'h00, 3'h1, 4'hf, 8'h0, 16'h2000, 2'h0, 8'h2f, 1'h1, 1'h0},
               '{16'h50fc, 6'h02, 3'h2, 4'h0, 8'h7, 16'h0, 2'h0, 8'h07, 1'h1, 1'h1},
               '{16'h50fc, 6'h00, 3'h2, 4'h0, 8'h7, 16'h0, 2'h0, 8'h00, 1'h0, 1'h0},
               '{16'h80fc, 6'h01, 3'h3, 4'h0, 8'h5, 16'h2000, 2'h0, 8'h05, 1'h1, 1'h1},
               '{16'h4afc, 6'h20, 3'h0, 4'h0, 8'h0, 16'h0, 2'h0, 8'h04, 1'h0, 1'h0},
               '{16'h4e7b, 6'h14, 3'h0, 4'h0, 8'h0, 16'h2000, 2'h0, 8'h04, 1'h0, 1'h0},
               '{16'ha123, 6'h00, 3'h0, 4'h0, 8'h0, 16'h0, 2'h0, 8'h0a, 1'h0, 1'h0},
               '{16'hf000, 6'h08, 3'h0, 4'h0, 8'h0, 16'h2000, 2'h0, 8'h0b, 1'h0, 1'h0},
               '{16'hf000, 6'h08, 3'h0, 4'h0, 8'h0, 16'h0, 2'h0, 8'h08, 1'h0, 1'h0},
               '{16'h4e73, 6'h04, 3'h0, 4'h0, 8'h0, 16'h0, 2'h0, 8'h08, 1'h0, 1'h0},
               '{16'hf200, 6'h00, 3'h0, 4'h0, 8'h0, 16'h0, 2'h0, 8'h00, 1'h0, 1'h0},
               '{16'hf200, 6'h00, 3'h0, 4'h0, 8'h0, 16'h0, 2'h1, 8'h0b, 1'h0, 1'h0},
               '{16'hf200, 6'h00, 3'h0, 4'h0, 8'h0, 16'h0, 2'h2, 8'h08, 1'h0, 1'h0}};
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      @(negedge clk);
      chk("halt", 32'h0, 32'(halt));
      rd_reg(8'h00);
      chk("vbr reset", 32'h0, d);
      @(posedge clk);
      wr <= 1'h1;
      wdata <= 32'h100;
      @(posedge clk);
      wr <= 1'h0;
      rd_reg(8'h00);
      chk("vbr", 32'h100, d);
      rd_reg(8'hfc);
      chk("unmapped", 32'h0, d);
      $display("test registers done");
      // table rows; coprocessor rows also check the cycle
      foreach (rows[i]) begin
         // let the answer pins of the last cycle drain through the synchroniser
         repeat (4) @(posedge clk);
         send(rows[i]);
         if (rows[i].op[15:9] > 7'h78) begin
            @(negedge clk);
            chk("cp cycle", 32'({1'h1, 4'h2, rows[i].op[11:9]}), 32'(cp));
         end
         wait_exc();
         check(rows[i]);
      end
      rd_reg(8'h04);
      chk("last vector", 32'h8, 32'(d[7:0]));
      // traced trap: trace only after return
      @(posedge clk);
      send(TR);
      wait_exc();
      check(TR);
      chk("trace early", 32'h0, 32'(trace));
      @(posedge clk);
      return_from_exception <= 1'h1;
      @(posedge clk);
      return_from_exception <= 1'h0;
      @(negedge clk);
      chk("trace", 32'h1, 32'(trace));
      $display("test trace done");
      // even then odd prefetch
      @(posedge clk);
      f_req <= 1'h1;
      f_addr <= 32'h1000;
      @(negedge clk);
      chk("fetch even", 32'h1, 32'(go));
      @(posedge clk);
      f_addr <= 32'h1001;
      f_mid <= 1'h1;
      @(negedge clk);
      chk("fetch odd", 32'h0, 32'(go));
      // drop the request once taken, a second odd fetch would be a double fault
      @(posedge clk);
      f_req <= 1'h0;
      @(negedge clk);
      wait_exc();
      chk("frame", 32'(cev_pkg::FR_LONG), 32'(exc.frame));
      check(AE);
      // breakpoint cycle ended by bus error
      @(posedge clk);
      breakpoint_instruction <= 1'h1;
      @(posedge clk);
      breakpoint_instruction <= 1'h0;
      wait_exc();
      check(BK);
      // odd prefetch during fault processing
      @(posedge clk);
      f_seq <= 1'h1;
      f_req <= 1'h1;
      repeat (4) @(negedge clk);
      chk("double fault", 32'h1, 32'(halt));
      repeat (20) @(negedge clk);
      chk("halt held", 32'h1, 32'(halt));
      @(posedge clk);
      rst_n <= 1'h0;
      f_seq <= 1'h0;
      f_req <= 1'h0;
      @(posedge clk);
      rst_n <= 1'h1;
      @(negedge clk);
      chk("halt after reset", 32'h0, 32'(halt));
      $display("test double fault done");
      finish_test();
   end
endmodule
